/* hdl/quad_rail_mode_sequencer.sv */
// Purpose: Digital mode and fault sequencing of a four-rail regulator
// Assumes: Comparator results arrive asynchronously on pins
// Notes: Good outputs are open drain, enable high means pulling low
// How it works
// - All enables low keeps everything off
// - First wake waits start-up delay
// - Good rises at upper threshold
// - Active mode starts further rails immediately
// - All enables low returns to shutdown
// - Good drops below lower threshold, hysteresis
// - Good stays low for minimum hold
// - OV/thermal drop good, shutdown after grace
// - Undervoltage shuts rails down immediately
// - Restart rails in order with gaps
// - Thermal fault adds safety wait first
// - Enable low drops good, discharges rail
// - Rail-three select chooses output level
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.svh"
module quad_rail_mode_sequencer
   import rail_seq_pkg::*;
#(
   parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
   parameter int RESTART_GAP_CYCLES = `RESTART_GAP_CYCLES,
   parameter int PG_HOLD_CYCLES = `PG_HOLD_CYCLES,
   parameter int FAULT_GRACE_CYCLES = `FAULT_GRACE_CYCLES,
   parameter int THERMAL_SAFETY_CYCLES = `THERMAL_SAFETY_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clkEn,
   // Host pins
   input wire logic [3:0] converterEnable,
   input wire logic rail3LevelSelect,
   // Comparators
   input wire logic [3:0] outputAboveHigh,
   input wire logic [3:0] outputBelowLow,
   input wire fault_in_t faultIn,
   // Open-drain good lines, drive low when enabled
   output logic [3:0] converterOutputGoodOut,
   output logic [3:0] converterOutputGoodOe,
   // Analog controls
   output logic referenceOn,
   output logic [3:0] converterRun,
   output logic [3:0] dischargeOn,
   output logic rail3HighLevel
);
   localparam int TW = $clog2(THERMAL_SAFETY_CYCLES + 1);
   logic [1:0] rstSync_r;
   logic rstN;
   logic [3:0] enMeta_r, enSync_r, hiMeta_r, hiSync_r, loMeta_r, loSync_r;
   fault_in_t fMeta_r, fSync_r;
   logic selMeta_r, selSync_r;
   seq_state_t state_r;
   logic [TW-1:0] timer_r;
   logic [TW-1:0] graceCnt_r;
   logic [1:0] slot_r;
   logic sawThermal_r;
   logic [3:0] good;
   logic anyEn, ovTemp, uv, faultLatch;

   // ------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rstSync_r <= 2'b00;
      else
         rstSync_r <= {rstSync_r[0], 1'b1};
   end
   assign rstN = rstSync_r[1];

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         enMeta_r <= 4'h0;
         enSync_r <= 4'h0;
         hiMeta_r <= 4'h0;
         hiSync_r <= 4'h0;
         loMeta_r <= 4'h0;
         loSync_r <= 4'h0;
         fMeta_r <= '0;
         fSync_r <= '0;
         selMeta_r <= 1'b0;
         selSync_r <= 1'b0;
      end
      else if (clkEn)
      begin
         enMeta_r <= converterEnable;
         enSync_r <= enMeta_r;
         hiMeta_r <= outputAboveHigh;
         hiSync_r <= hiMeta_r;
         loMeta_r <= outputBelowLow;
         loSync_r <= loMeta_r;
         fMeta_r <= faultIn;
         fSync_r <= fMeta_r;
         selMeta_r <= rail3LevelSelect;
         selSync_r <= selMeta_r;
      end
   end

   assign anyEn = |enSync_r;
   assign ovTemp = fSync_r.overvoltage || fSync_r.overtemperature;
   assign uv = fSync_r.undervoltage;
   assign faultLatch = uv || (ovTemp && graceCnt_r >= TW'(FAULT_GRACE_CYCLES - 1));

   // ------------------------------------------------------------
   // Fault grace timer
   // ------------------------------------------------------------
   // Grace before shutdown
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
         graceCnt_r <= '0;
      else if (clkEn)
      begin
         if (!ovTemp)
            graceCnt_r <= '0;
         else if (graceCnt_r < TW'(FAULT_GRACE_CYCLES - 1))
            graceCnt_r <= graceCnt_r + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Mode sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         state_r <= SHUTDOWN;
         timer_r <= '0;
         slot_r <= 2'd0;
         sawThermal_r <= 1'b0;
         converterRun <= 4'h0;
         referenceOn <= 1'b0;
      end
      else if (clkEn)
      begin
         converterRun <= converterRun & enSync_r;
         if (faultLatch && state_r != FAULT_OFF)
         begin
            state_r <= FAULT_OFF;
            converterRun <= 4'h0;
            sawThermal_r <= fSync_r.overtemperature;
         end
         else
         begin
            case (state_r)
               SHUTDOWN:
               begin
                  converterRun <= 4'h0;
                  referenceOn <= 1'b0;
                  if (anyEn)
                  begin
                     state_r <= WAKING;
                     referenceOn <= 1'b1;
                     timer_r <= TW'(STARTUP_CYCLES - 1);
                  end
               end
               WAKING:
               begin
                  if (!anyEn)
                     state_r <= SHUTDOWN;
                  else if (timer_r == '0)
                  begin
                     state_r <= ACTIVE;
                     converterRun <= enSync_r;
                  end
                  else
                     timer_r <= timer_r - 1'b1;
               end
               ACTIVE:
               begin
                  converterRun <= enSync_r;
                  if (!anyEn)
                  begin
                     state_r <= SHUTDOWN;
                     referenceOn <= 1'b0;
                  end
               end
               FAULT_OFF:
               begin
                  converterRun <= 4'h0;
                  if (fSync_r.overtemperature)
                     sawThermal_r <= 1'b1;
                  if (!ovTemp && !uv)
                  begin
                     if (sawThermal_r)
                     begin
                        state_r <= THERMAL_WAIT;
                        timer_r <= TW'(THERMAL_SAFETY_CYCLES - 1);
                     end
                     else
                     begin
                        state_r <= RESTARTING;
                        slot_r <= 2'd0;
                        timer_r <= '0;
                     end
                  end
               end
               THERMAL_WAIT:
               begin
                  if (timer_r == '0)
                  begin
                     state_r <= RESTARTING;
                     slot_r <= 2'd0;
                  end
                  else
                     timer_r <= timer_r - 1'b1;
               end
               RESTARTING:
               begin
                  if (timer_r == '0)
                  begin
                     converterRun[slot_r] <= enSync_r[slot_r];
                     timer_r <= TW'(RESTART_GAP_CYCLES - 1);
                     slot_r <= slot_r + 2'd1;
                     if (slot_r == 2'(`RAIL_COUNT - 1))
                        state_r <= anyEn ? ACTIVE : SHUTDOWN;
                  end
                  else
                     timer_r <= timer_r - 1'b1;
               end
               default:
                  state_r <= SHUTDOWN;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Power-good per rail
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `RAIL_COUNT; g++)
      begin : goodGen
         rail_good_ctrl #(
            .HOLD_CYCLES(PG_HOLD_CYCLES)
         ) goodInst (
            .clk(clk),
            .rstN(rstN),
            .clkEn(clkEn),
            .railOn(converterRun[g]),
            .forceLow(ovTemp || uv || !enSync_r[g]),
            .aboveHigh(hiSync_r[g]),
            .belowLow(loSync_r[g]),
            .good(good[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Output pins
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         converterOutputGoodOut <= 4'h0;
         converterOutputGoodOe <= 4'hf;
         dischargeOn <= 4'hf;
         rail3HighLevel <= 1'b0;
      end
      else if (clkEn)
      begin
         converterOutputGoodOut <= 4'h0;
         converterOutputGoodOe <= ~good;
         dischargeOn <= ~enSync_r;
         rail3HighLevel <= selSync_r;
      end
   end
endmodule : quad_rail_mode_sequencer
`default_nettype wire

/* hdl/rail_seq_defs.svh */
// Purpose: Timing constants for the quad rail mode sequencer
// Assumes: 250 MHz clock
// Notes: Least times round up, cycle counts derived from the times
`ifndef RAIL_SEQ_DEFS_SVH
`define RAIL_SEQ_DEFS_SVH
`define CLK_MHZ 250
`define STARTUP_DELAY_US 420
`define STARTUP_CYCLES (`STARTUP_DELAY_US * `CLK_MHZ)
`define RESTART_GAP_US 500
`define RESTART_GAP_CYCLES (`RESTART_GAP_US * `CLK_MHZ)
`define PG_HOLD_MS 50
`define PG_HOLD_CYCLES (`PG_HOLD_MS * 1000 * `CLK_MHZ)
`define FAULT_GRACE_MS 5
`define FAULT_GRACE_CYCLES (`FAULT_GRACE_MS * 1000 * `CLK_MHZ)
`define THERMAL_SAFETY_S 2
`define THERMAL_SAFETY_CYCLES (`THERMAL_SAFETY_S * 1000000 * `CLK_MHZ)
`define RAIL_COUNT 4
`define RAIL3_INDEX 2
`endif

/* hdl/rail_seq_pkg.sv */
// Purpose: Shared types for the quad rail mode sequencer
// Assumes: Four rails
// Notes: Types only, numbers live in the defs header
package rail_seq_pkg;
   typedef enum logic [2:0] {
      SHUTDOWN,
      WAKING,
      ACTIVE,
      FAULT_OFF,
      THERMAL_WAIT,
      RESTARTING
   } seq_state_t;
   typedef struct packed {
      logic overvoltage;
      logic overtemperature;
      logic undervoltage;
   } fault_in_t;
endpackage : rail_seq_pkg

/* hdl/rail_good_ctrl.sv */
// Purpose: One rail's power-good flag with minimum low hold
// Assumes: Window inputs already synchronised
// Notes: Hold counter reloads on every forced-low cycle
`timescale 1ns/1ps
`default_nettype none
module rail_good_ctrl
#(
   parameter int HOLD_CYCLES = 12500000
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstN,
   input wire logic clkEn,
   // Conditions
   input wire logic railOn,
   input wire logic forceLow,
   input wire logic aboveHigh,
   input wire logic belowLow,
   // Result
   output logic good
);
   localparam int CW = $clog2(HOLD_CYCLES + 1);
   logic [CW-1:0] holdCnt_r;
   logic dropped_r;
   logic lowNow;
   assign lowNow = forceLow || !railOn || belowLow || (dropped_r && !aboveHigh);
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
         holdCnt_r <= '0;
      else if (clkEn)
      begin
         if (lowNow)
            holdCnt_r <= CW'(HOLD_CYCLES);
         else if (holdCnt_r != '0)
            holdCnt_r <= holdCnt_r - 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
         dropped_r <= 1'b1;
      else if (clkEn)
      begin
         if (belowLow || !railOn)
            dropped_r <= 1'b1;
         else if (aboveHigh)
            dropped_r <= 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
         good <= 1'b0;
      else if (clkEn)
         good <= !lowNow && (holdCnt_r == '0) && !dropped_r;
   end
endmodule : rail_good_ctrl
`default_nettype wire

/* verif/quad_rail_mode_sequencer_properties.sv */
// Purpose: Pin-level timing checks for the sequencer
// Assumes: clkEn held high, shortened counts
// Notes: Margins allow for two-flop input sync
`timescale 1ns/1ps
`default_nettype none
module quad_rail_mode_sequencer_properties
   import rail_seq_pkg::*;
#(
   parameter int STARTUP_CYCLES = 20,
   parameter int PG_HOLD_CYCLES = 50,
   parameter int FAULT_GRACE_CYCLES = 15
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic [3:0] converterEnable,
   input wire logic rail3LevelSelect,
   input wire logic [3:0] outputAboveHigh,
   input wire logic [3:0] outputBelowLow,
   input wire fault_in_t faultIn,
   input wire logic [3:0] converterOutputGoodOut,
   input wire logic [3:0] converterOutputGoodOe,
   input wire logic referenceOn,
   input wire logic [3:0] converterRun,
   input wire logic [3:0] dischargeOn,
   input wire logic rail3HighLevel
);
   logic [15:0] enHist_r;
   logic [3:0] offLong;
   int wakeCnt_r, lowCnt_r, hotCnt_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // History starts high so nothing is assumed off
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) enHist_r <= '1;
      else enHist_r <= {enHist_r[11:0], converterEnable};
   assign offLong = ~(converterEnable | enHist_r[3:0] | enHist_r[7:4] | enHist_r[11:8]
      | enHist_r[15:12]);
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) wakeCnt_r <= 0;
      else if (!referenceOn) wakeCnt_r <= 0;
      else if (wakeCnt_r < 1000) wakeCnt_r <= wakeCnt_r + 1;
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) lowCnt_r <= 0;
      else if (!converterOutputGoodOe[0]) lowCnt_r <= 0;
      else if (lowCnt_r < 1000) lowCnt_r <= lowCnt_r + 1;
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) hotCnt_r <= 0;
      else if (!(faultIn.overvoltage || faultIn.overtemperature)) hotCnt_r <= 0;
      else if (hotCnt_r < 1000) hotCnt_r <= hotCnt_r + 1;
   AST_OFF_STOPS: assert property (offLong != 4'h0 |-> (converterRun & offLong) == 4'h0
      && (dischargeOn & offLong) == offLong && (converterOutputGoodOe & offLong) == offLong)
      else $error("disabled rail still running or good");
   AST_SHUTDOWN: assert property (offLong == 4'hF |-> !referenceOn && converterRun == 4'h0)
      else $error("not in shutdown with all enables low");
   AST_WAKE_WAIT: assert property (referenceOn && wakeCnt_r < STARTUP_CYCLES - 1
      |-> converterRun == 4'h0) else $error("rail started before wake delay");
   AST_GRACE_STOP: assert property (hotCnt_r > FAULT_GRACE_CYCLES + 4
      |-> converterRun == 4'h0) else $error("rails kept running past grace");
   AST_FAULT_GOOD: assert property ((faultIn.overvoltage || faultIn.overtemperature)[*4]
      |=> converterOutputGoodOe == 4'hF) else $error("good not dropped on fault");
   AST_UV_STOP: assert property (faultIn.undervoltage[*4] |=> converterRun == 4'h0)
      else $error("rails running under low input");
   AST_HOLD_MIN: assert property ($fell(converterOutputGoodOe[0])
      |-> lowCnt_r >= PG_HOLD_CYCLES - 1) else $error("good low too short");
   AST_DROP_LOW: assert property (outputBelowLow[0][*4] |=> converterOutputGoodOe[0])
      else $error("good high with output low");
   // Good line is two registers behind run, and this compares with last cycle's run
   AST_GOOD_RUN: assert property (!converterOutputGoodOe[0] |-> $past(converterRun[0]))
      else $error("good high on stopped rail");
   AST_OD_LOW: assert property (converterOutputGoodOut == 4'h0)
      else $error("open drain output driven high");
   AST_LEVEL: assert property ($stable(rail3LevelSelect)[*8]
      |=> rail3HighLevel == $past(rail3LevelSelect)) else $error("rail3 level wrong");
   COV_LAST_RAIL: cover property ($rose(converterRun[3]));
   COV_GOOD_BACK: cover property ($fell(converterOutputGoodOe[0]));
   COV_HOT: cover property (hotCnt_r > FAULT_GRACE_CYCLES + 4);
endmodule : quad_rail_mode_sequencer_properties
bind quad_rail_mode_sequencer quad_rail_mode_sequencer_properties #(
   .STARTUP_CYCLES(STARTUP_CYCLES), .PG_HOLD_CYCLES(PG_HOLD_CYCLES),
   .FAULT_GRACE_CYCLES(FAULT_GRACE_CYCLES)) props_u (.clk(clk), .reset_n(reset_n),
   .clkEn(clkEn), .converterEnable(converterEnable), .rail3LevelSelect(rail3LevelSelect),
   .outputAboveHigh(outputAboveHigh), .outputBelowLow(outputBelowLow), .faultIn(faultIn),
   .converterOutputGoodOut(converterOutputGoodOut),
   .converterOutputGoodOe(converterOutputGoodOe), .referenceOn(referenceOn),
   .converterRun(converterRun), .dischargeOn(dischargeOn), .rail3HighLevel(rail3HighLevel));
`default_nettype wire

/* verif/rail_plant_model.sv */
// Purpose: Rail outputs, comparators and host pull-ups
// Assumes: Output settles two cycles after run
// Notes: Sag forces a rail below its lower threshold
`timescale 1ns/1ps
`default_nettype none
module rail_plant_model
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] converterRun,
   input wire logic [3:0] sagIn,
   input wire logic [3:0] converterOutputGoodOe,
   output logic [3:0] outputAboveHigh,
   output logic [3:0] outputBelowLow,
   output logic [3:0] goodLine
);
   logic [3:0] rise1_r, rise2_r;
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) rise1_r <= '0;
      else rise1_r <= converterRun;
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) rise2_r <= '0;
      else rise2_r <= rise1_r & converterRun;
   assign goodLine = ~converterOutputGoodOe;
   assign outputAboveHigh = rise2_r & ~sagIn;
   assign outputBelowLow = ~rise2_r | sagIn;
endmodule : rail_plant_model
`default_nettype wire

/* verif/quad_rail_mode_sequencer_test.sv */
// Purpose: Self-checking bench for the sequencer
// Assumes: Shortened counts, clkEn tied high
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module quad_rail_mode_sequencer_test;
   import rail_seq_pkg::*;
   localparam int STARTUP = 20, GAP = 10, HOLD = 50, GRACE = 15, SAFE = 40;
   logic clk = 1'b0, reset_n = 1'b0, sel = 1'b0, refOn, high3;
   logic [3:0] en = '0, sag = '0, above, below, goodOut, goodOe, run, dis, goodLine;
   fault_in_t fault = '0;
   int error_cnt = 0, num_checks = 0, n, first;
   int t [4];
   integer seed = 32'h8978_2043;
   always #2 clk = ~clk;
   quad_rail_mode_sequencer #(.STARTUP_CYCLES(STARTUP), .RESTART_GAP_CYCLES(GAP),
      .PG_HOLD_CYCLES(HOLD), .FAULT_GRACE_CYCLES(GRACE), .THERMAL_SAFETY_CYCLES(SAFE))
      dut_u (.clk(clk), .reset_n(reset_n), .clkEn(1'b1), .converterEnable(en),
      .rail3LevelSelect(sel), .outputAboveHigh(above), .outputBelowLow(below),
      .faultIn(fault), .converterOutputGoodOut(goodOut), .converterOutputGoodOe(goodOe),
      .referenceOn(refOn), .converterRun(run), .dischargeOn(dis), .rail3HighLevel(high3));
   rail_plant_model plant_u (.clk(clk), .reset_n(reset_n), .converterRun(run), .sagIn(sag),
      .converterOutputGoodOe(goodOe), .outputAboveHigh(above), .outputBelowLow(below),
      .goodLine(goodLine));
   function automatic int slot(input int f, input int j);
      return (j - f) * GAP;
   endfunction : slot
   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask : tick
   task automatic check_val(input logic [3:0] got, input logic [3:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t value %h expected %h", $time, got, exp);
      end
   endtask : check_val
   task automatic check_span(input int got, input int lo, input int hi);
      num_checks++;
      if (got < lo || got > hi)
      begin
         error_cnt++;
         $display("MISMATCH %0t count %0d outside %0d to %0d", $time, got, lo, hi);
      end
   endtask : check_span
   task automatic wait_on(input logic line, input int i, input logic v, output int c);
      c = 0;
      while ((line ? goodLine[i] : run[i]) !== v && c < 2000)
      begin
         tick(1);
         c++;
      end
   endtask : wait_on
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      close_out();
   end
   initial
   begin
      tick(5);
      reset_n = 1'b1;
      tick(6);
      en = 4'h1;
      wait_on(0, 0, 1'b1, n);
      check_span(n, STARTUP, STARTUP + 8);
      check_val({3'b0, refOn}, 4'h1);
      wait_on(1, 0, 1'b1, n);
      check_span(n, 1, HOLD + 8);
      en = 4'h3;
      wait_on(0, 1, 1'b1, n);
      check_span(n, 1, 6);
      sag = 4'h1;
      tick(6);
      check_val(goodLine & 4'h1, 4'h0);
      sag = 4'h0;
      wait_on(1, 0, 1'b1, n);
      check_span(n, HOLD - 6, HOLD + 8);
      fault.overvoltage = 1'b1;
      tick(5);
      check_val(goodLine, 4'h0);
      tick(4);
      fault = '0;
      tick(6);
      check_val(run, 4'h3);
      for (int k = 0; k < 3; k++)
      begin
         tick(HOLD);
         fault.undervoltage = 1'b1;
         tick(5);
         check_val(run, 4'h0);
         en = 4'($random(seed)) | 4'h2;
         tick(3);
         fault = '0;
         t = '{-1, -1, -1, -1};
         for (int c = 0; c < 80; c++)
         begin
            tick(1);
            for (int i = 0; i < 4; i++)
               if (run[i] === 1'b1 && t[i] < 0) t[i] = c;
         end
         first = en[0] ? 0 : 1;
         for (int i = 0; i < 4; i++)
            if (en[i]) check_span(t[i] - t[first], slot(first, i), slot(first, i) + 1);
            else check_span(t[i], -1, -1);
      end
      en = 4'hF;
      tick(60);
      fault.overtemperature = 1'b1;
      tick(GRACE + 8);
      check_val(run, 4'h0);
      fault = '0;
      wait_on(0, 0, 1'b1, n);
      check_span(n, SAFE, SAFE + 8);
      tick(40);
      for (int k = 0; k < 6; k++)
      begin
         sel = 1'($random(seed));
         tick(8);
         check_val({3'b0, high3}, {3'b0, sel});
      end
      en = 4'h4;
      tick(6);
      check_val(run & 4'hB, 4'h0);
      check_val(dis, 4'hB);
      check_val(goodLine & 4'hB, 4'h0);
      en = 4'h0;
      tick(6);
      check_val({refOn, run[2:0]}, 4'h0);
      check_val(run, 4'h0);
      close_out();
   end
endmodule : quad_rail_mode_sequencer_test
`default_nettype wire
